// File: crd_pkg.sv
package crd_pkg;

	// stages in each reset release synchroniser
	localparam int CRD_SYNC_STAGES = 2;

	// reset value of the captured byte-order strap (0 = big endian)
	localparam logic CRD_ENDIAN_RESET = 1'h0;

	// reset value of the power-up flag; a block reset counts as power-up
	localparam logic CRD_POWER_UP_RESET = 1'h1;

	// reset-state output levels
	localparam logic CRD_RST_ASSERTED = 1'h0;

	// active level of each reset source at the block's inputs
	localparam logic CRD_MST_ACTIVE = 1'h0;
	localparam logic CRD_POR_ACTIVE = 1'h1;
	localparam logic CRD_WDT_ACTIVE = 1'h1;

	// strap level that selects little-endian chip-select space
	localparam logic CRD_STRAP_LITTLE = 1'h1;

endpackage

// File: crd_reset_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: master reset low resets every module except reset and clock control.
// RULE2: an active-low reset output is driven from the watchdog reset path.
// RULE3: power-on, master reset or watchdog time-out each assert reset out.
// RULE4: power-on reset input is active high, flags a fresh power-up.
// RULE5: strap high during reset selects little-endian chip-select space.
// RULE6: each asynchronous source is release-synchronised before reset ends.
module crd_reset_ctrl
	import crd_pkg::*;
(
	// system clock and the block's own reset
	input  wire logic clock,
	input  wire logic rst_n,
	// reset sources
	input  wire logic master_reset_n,
	input  wire logic power_on_reset,
	input  wire logic wdog_timeout,
	// byte-order strap
	input  wire logic endian_strap,
	// reset outputs
	output logic      module_reset_n,
	output logic      reset_out_n,
	output logic      power_up_flag,
	output logic      cs_little_endian
);

	// width of every synchroniser chain
	typedef logic [CRD_SYNC_STAGES-1:0] crd_sync_type;

	// shift one level in; the top stage is the oldest sample
	function automatic crd_sync_type crd_shift(
		input crd_sync_type q,
		input logic         d
	);
		crd_sync_type nxt;
		nxt = {q[CRD_SYNC_STAGES-2:0], d};
		return nxt;
	endfunction

	// a chain counts as settled once its last stage shows the level
	function automatic logic crd_sync_last(
		input crd_sync_type q
	);
		logic last;
		last = q[CRD_SYNC_STAGES-1];
		return last;
	endfunction

	// true while an input sits at its active level, whatever its polarity
	function automatic logic crd_src_active(
		input logic level,
		input logic active_level
	);
		logic active;
		active = (level == active_level);
		return active;
	endfunction

	// strap level to byte order
	function automatic logic crd_strap_little(
		input logic level
	);
		logic little;
		little = (level == CRD_STRAP_LITTLE);
		return little;
	endfunction

	// synchroniser chains, one per asynchronous input
	crd_sync_type mst_sync_q;
	crd_sync_type por_sync_q;
	crd_sync_type wdt_sync_q;
	crd_sync_type strap_sync_q;

	// reset output flops
	logic         module_reset_n_q;
	logic         reset_out_n_q;

	// status output flops
	logic         power_up_q;
	logic         endian_q;

	// next values of the reset flops
	logic         module_reset_n_d;
	logic         reset_out_n_d;

	// next values of the status flops
	logic         power_up_d;
	logic         endian_d;

	// sources normalised to active high
	logic         mst_active;
	logic         por_active;
	logic         wdt_active;

	// clear terms of the synchroniser chains
	logic         mst_clr_n;
	logic         por_clr_n;
	logic         wdt_clr_n;

	// sources still held after synchronisation
	logic         mst_held;
	logic         por_held;
	logic         wdt_held;
	logic         in_reset;

	// strap decode and the window in which it is followed
	logic         strap_little;
	logic         strap_window;

	// polarity of each source folded away here, once
	assign mst_active = crd_src_active(master_reset_n, CRD_MST_ACTIVE);
	assign por_active = crd_src_active(power_on_reset, CRD_POR_ACTIVE);
	assign wdt_active = crd_src_active(wdog_timeout, CRD_WDT_ACTIVE);

	// block reset or an active source clears that source's chain at once
	assign mst_clr_n = rst_n & ~mst_active;  // RULE1
	assign por_clr_n = rst_n & ~por_active;  // RULE4
	assign wdt_clr_n = rst_n & ~wdt_active;  // RULE3

	// master reset release; assertion stays asynchronous
	always_ff @(posedge clock or negedge mst_clr_n) begin
		if (!mst_clr_n) begin
			mst_sync_q <= '0;
		end else begin
			mst_sync_q <= crd_shift(mst_sync_q, 1'h1);  // RULE6
		end
	end

	// power-on reset release
	always_ff @(posedge clock or negedge por_clr_n) begin
		if (!por_clr_n) begin
			por_sync_q <= '0;
		end else begin
			por_sync_q <= crd_shift(por_sync_q, 1'h1);  // RULE6
		end
	end

	// watchdog time-out release
	always_ff @(posedge clock or negedge wdt_clr_n) begin
		if (!wdt_clr_n) begin
			wdt_sync_q <= '0;
		end else begin
			wdt_sync_q <= crd_shift(wdt_sync_q, 1'h1);  // RULE6
		end
	end

	// strap crosses in from a pin, two flops before use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_sync_q <= '0;
		end else begin
			strap_sync_q <= crd_shift(strap_sync_q, endian_strap);
		end
	end

	// a source stays held until its chain has run through
	assign mst_held = ~crd_sync_last(mst_sync_q);  // RULE1
	assign por_held = ~crd_sync_last(por_sync_q);  // RULE4
	assign wdt_held = ~crd_sync_last(wdt_sync_q);  // RULE3

	// any source still held keeps everyone in reset
	assign in_reset = mst_held | por_held | wdt_held;  // RULE3

	// followed through the release edge too, so a short reset still lands
	assign strap_window = (module_reset_n_q == CRD_RST_ASSERTED);  // RULE5
	assign strap_little = crd_strap_little(crd_sync_last(strap_sync_q));

	// both resets share one decode, so they leave on the same edge
	assign module_reset_n_d = ~in_reset;  // RULE1
	assign reset_out_n_d    = ~in_reset;  // RULE2

	// set wins while power-on is pending; cleared only as reset ends
	assign power_up_d = por_held | (power_up_q & in_reset);  // RULE4

	// byte order frozen once the block is running
	assign endian_d = strap_window ? strap_little : endian_q;  // RULE5

	// reset to all modules except this block and clock control
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			module_reset_n_q <= CRD_RST_ASSERTED;
		end else begin
			module_reset_n_q <= module_reset_n_d;  // RULE1
		end
	end

	// reset pin, driven on the same edge as the module reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reset_out_n_q <= CRD_RST_ASSERTED;
		end else begin
			reset_out_n_q <= reset_out_n_d;  // RULE2
		end
	end

	// power-up flag; any block reset counts as a fresh power-up
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_up_q <= CRD_POWER_UP_RESET;
		end else begin
			power_up_q <= power_up_d;  // RULE4
		end
	end

	// captured byte order of the chip-select space
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			endian_q <= CRD_ENDIAN_RESET;
		end else begin
			endian_q <= endian_d;  // RULE5
		end
	end

	// reset outputs straight from their flops
	assign module_reset_n   = module_reset_n_q;
	assign reset_out_n      = reset_out_n_q;

	// status outputs straight from their flops
	assign power_up_flag    = power_up_q;
	assign cs_little_endian = endian_q;

endmodule

// File: crd_board.sv
`timescale 1ns/1ps
// board side: pins follow the bench one edge late
module crd_board (
	input  wire logic clock, por_cmd, mr_cmd, strap_cmd,
	output logic      power_on_reset, master_reset_n, endian_strap);
	always_ff @(posedge clock) begin
		power_on_reset <= por_cmd;
		master_reset_n <= !mr_cmd;
		endian_strap   <= strap_cmd;
	end
endmodule

// File: crd_reset_ctrl_props.sv
`timescale 1ns/1ps
module crd_reset_ctrl_props (
	input wire logic clock, rst_n, master_reset_n, power_on_reset,
	input wire logic wdog_timeout, endian_strap, module_reset_n,
	input wire logic reset_out_n, power_up_flag, cs_little_endian);
	// any source active; release waits for all
	wire s = !master_reset_n | power_on_reset | wdog_timeout;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_src_low: assert property (s |=> !reset_out_n)
		else $error("source gave no reset");
	a_hold_low: assert property ($fell(s) |-> !reset_out_n[*3])
		else $error("reset released early");
	a_late_rise: assert property ($fell(s) ##1 !s ##1 !s |=> reset_out_n)
		else $error("reset released late");
	a_same_out: assert property (reset_out_n == module_reset_n)
		else $error("reset outputs differ");
	a_por_flag: assert property (power_on_reset |=> power_up_flag)
		else $error("power-up flag missing");
	a_strap_frz: assert property ($past(reset_out_n) && reset_out_n |->
		$stable(cs_little_endian)) else $error("byte order moved");
endmodule
bind crd_reset_ctrl crd_reset_ctrl_props crd_reset_ctrl_props_i (.*);

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clock = 0, rst_n = 0, wdog_timeout = 0, por_cmd = 0, mr_cmd = 0;
	logic strap_cmd = 0;
	wire power_on_reset, master_reset_n, endian_strap, module_reset_n;
	wire reset_out_n, power_up_flag, cs_little_endian;
	int mismatches = 0, num_checks = 0, cycles = 0;
	crd_board crd_board_i (.*);
	crd_reset_ctrl crd_reset_ctrl_i (.*);
	initial forever #5 clock = ~clock;
	task automatic chk(logic seen, logic exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wt(int n); repeat (n) @(posedge clock); #1; endtask
	// each source alone pulls reset, release is synchronised
	task automatic t_sources;
		for (int k = 0; k < 3; k++) begin
			@(posedge clock);
			{por_cmd, mr_cmd, wdog_timeout} <= 3'h4 >> k;
			wt(3); chk(module_reset_n, 1'b0);
			@(posedge clock);
			{por_cmd, mr_cmd, wdog_timeout} <= 3'h0;
			wt(2); chk(reset_out_n, 1'b0);
			wt(3); chk(reset_out_n, 1'b1);
		end
	endtask
	// strap taken in reset, then ignored once running
	task automatic t_strap;
		@(posedge clock); {strap_cmd, por_cmd} <= 2'h3;
		wt(4); chk(power_up_flag, 1'b1);
		@(posedge clock); por_cmd <= 1'b0;
		wt(6); chk(cs_little_endian, 1'b1);
		chk(power_up_flag, 1'b0);
		@(posedge clock); strap_cmd <= 1'b0;
		wt(5); chk(cs_little_endian, 1'b1);
	endtask
	// block reset mid-run, then a power-on with the strap low
	task automatic t_restart;
		@(posedge clock); strap_cmd <= 1'b1; rst_n <= 1'b0;
		wt(3); chk(module_reset_n, 1'b0);
		chk(power_up_flag, 1'b1);
		chk(cs_little_endian, 1'b0);
		@(posedge clock); rst_n <= 1'b1;
		wt(2); chk(reset_out_n, 1'b0);
		wt(1); chk(reset_out_n, 1'b1);
		chk(power_up_flag, 1'b0);
		chk(cs_little_endian, 1'b1);
		@(posedge clock); {strap_cmd, por_cmd} <= 2'h1;
		wt(4); chk(reset_out_n, 1'b0);
		@(posedge clock); por_cmd <= 1'b0;
		wt(6); chk(cs_little_endian, 1'b0);
		chk(power_up_flag, 1'b0);
	endtask
	// hang guard
	always @(posedge clock) if (++cycles == 1000) begin
		mismatches++;
		final_report;
	end
	initial begin
		repeat (20) @(posedge clock); rst_n <= 1'b1;
		t_sources; t_strap; t_restart; final_report;
	end
endmodule
